// ===== design/vclk_pkg.sv
// constants shared by the video clock generator digital logic
package vclk_pkg;
    localparam int unsigned NCO_WIDTH  = 16;
    localparam logic [15:0] FREQ_INIT  = 16'h2000;
    localparam logic [15:0] FREQ_MIN   = 16'h0100;
    localparam logic [15:0] FREQ_MAX   = 16'h8000;
    localparam logic [15:0] FREQ_GAIN  = 16'h0004;
    localparam logic [1:0]  REF_CNT_ZERO   = 2'h0;
    localparam logic [4:0]  WORD_CNT_ZERO  = 5'h00;
    localparam logic [4:0]  WORD_STEP_ONE  = 5'h01;
    localparam int unsigned WIDTH_SEL_BITS = 3;
    localparam int unsigned REF_SEL_BITS   = 2;
    // width modulus is 4 * (code + 1): code shifted up by two bits
    localparam int unsigned WIDTH_SHIFT    = 2;

    typedef enum logic [2:0] {
        pfd_idle = 3'b001,
        pfd_up   = 3'b010,
        pfd_down = 3'b100
    } pfd_state_type;
endpackage : vclk_pkg

// ===== design/video_clock_divider_pll_logic.sv
// digital divider, phase comparator and load clock logic of a video clock
// Summary of operation
// (RULE_01) reference divider divides crystal reference by 1 to 4, feeds comparator
// (RULE_02) word-width divider divides pixel clock by 4 to 32 in steps of 4
// (RULE_03) locked pixel rate equals reference times width modulus over ref modulus
// (RULE_04) phase comparator steers oscillator by error until phase and frequency match
// (RULE_05) exactly one load pulse per width modulus count of pixel clocks
// (RULE_06) all three load clocks come from the word-width divider output
// (RULE_07) differential pixel clock shifts, differential load clock loads shift register
// (RULE_08) load and pixel clock outputs all change on the same clock edge
// (RULE_09) system clock output comes from reference path, independent of pixel rate
// (RULE_10) gated load clocks start at next free load clock rising edge after gate high
// (RULE_11) width select is a static three-bit word, bit zero least significant
// (RULE_12) reference select is a static two-bit word, bit zero least significant
// (RULE_13) free load clock feeds the phase comparator, closing the loop
// (RULE_14) width modulus is four times code plus one; reference modulus code plus one
// (RULE_15) gate low at free load clock rising edge stops gated clocks without runt pulse
`timescale 1ns/10ps
`default_nettype none
module video_clock_divider_pll_logic
    import vclk_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      reset_n,
    input  wire logic                      crystal_tick,
    input  wire logic [WIDTH_SEL_BITS-1:0] width_select,
    input  wire logic [REF_SEL_BITS-1:0]   ref_select,
    input  wire logic                      video_gate_in,
    output logic                           pixel_clock_diff_p,
    output logic                           pixel_clock_diff_n,
    output logic                           free_load_clock,
    output logic                           gated_load_clock_single,
    output logic                           gated_load_clock_diff_p,
    output logic                           gated_load_clock_diff_n,
    output logic                           system_clock_out,
    output logic [NCO_WIDTH-1:0]           oscillator_tune
);
    // reference divider
    logic [1:0]           ref_cnt_r;
    logic                 ref_pulse_r;
    logic                 sys_clk_r;
    // tuned oscillator model: phase accumulator steered by the comparator
    logic [NCO_WIDTH-1:0] phase_acc_r;
    logic [NCO_WIDTH-1:0] freq_word_r;
    logic [NCO_WIDTH-1:0] freq_word_nxt;
    logic                 pix_r;
    // word-width divider and load clocks
    logic [4:0]           word_cnt_r;
    logic                 load_r;
    logic                 gate_r;
    logic                 gated_r;
    logic                 fb_pulse_r;
    // phase comparator and tuning clamps
    pfd_state_type        pfd_r;
    pfd_state_type        pfd_nxt;
    logic [NCO_WIDTH-1:0] freq_up_sat;
    logic [NCO_WIDTH-1:0] freq_down_sat;

    // decoded moduli, held as terminal counts
    wire logic [1:0] ref_last  = ref_select;                        // see (RULE_14)
    wire logic [4:0] word_last =
        5'({width_select, 2'b00} + {2'b00, 3'b011});                // see (RULE_14)
    wire logic       ref_wrap  = crystal_tick && (ref_cnt_r == ref_last);

    wire logic [NCO_WIDTH:0] acc_sum =
        {1'b0, phase_acc_r} + {1'b0, freq_word_r};
    wire logic       nco_tick  = acc_sum[NCO_WIDTH];
    // one pixel clock period is two oscillator ticks; rising edge counts
    wire logic       pix_rise  = nco_tick && !pix_r;
    wire logic       word_wrap = pix_rise && (word_cnt_r == word_last);
    // load level is high for exactly one pixel period per modulus count
    wire logic       load_nxt  = pix_rise ? word_wrap : load_r;     // see (RULE_05)
    wire logic       load_rise = pix_rise && word_wrap;
    // gate sampled only at the load rising edge, so pulses are whole
    wire logic       gate_nxt  = load_rise ? video_gate_in : gate_r; // see (RULE_10)
    wire logic       gated_nxt = load_nxt && gate_nxt;  // see (RULE_06) (RULE_15)

    // one gain step either way, clamped so the oscillator never stalls
    // and never wraps past its top rate
    wire logic [NCO_WIDTH-1:0] freq_up   = freq_word_r + FREQ_GAIN;
    wire logic [NCO_WIDTH-1:0] freq_down = freq_word_r - FREQ_GAIN;
    wire logic freq_up_over    = freq_up > FREQ_MAX;
    wire logic freq_down_under = (freq_down < FREQ_MIN)
                                 || (freq_down > freq_word_r);
    assign freq_up_sat   = freq_up_over ? FREQ_MAX : freq_up;
    assign freq_down_sat = freq_down_under ? FREQ_MIN : freq_down;

    // comparator inputs: both at once cancel, otherwise one leads
    wire logic both_pulse = ref_pulse_r && fb_pulse_r;
    wire logic ref_only   = ref_pulse_r && !fb_pulse_r;
    wire logic fb_only    = fb_pulse_r && !ref_pulse_r;

    // reference divider: count crystal ticks, pulse once per modulus
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ref_cnt_r   <= REF_CNT_ZERO;
            ref_pulse_r <= 1'b0;
        end else begin
            ref_pulse_r <= ref_wrap;                                // see (RULE_01)
            if (crystal_tick) begin
                ref_cnt_r <= ref_wrap ? REF_CNT_ZERO : 2'(ref_cnt_r + 2'h1);
            end
        end
    end

    // system clock toggles per crystal tick and never sees the pixel
    // loop, so the processor keeps its rate whatever the pixel rate
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sys_clk_r <= 1'b0;
        end else if (crystal_tick) begin
            sys_clk_r <= !sys_clk_r;                                // see (RULE_09)
        end
    end

    // oscillator model; the carry out of the accumulator is one tick
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_acc_r <= '0;
            pix_r       <= 1'b0;
        end else begin
            phase_acc_r <= acc_sum[NCO_WIDTH-1:0];
            if (nco_tick) begin
                pix_r <= !pix_r;
            end
        end
    end

    // word-width divider counts pixel rising edges only; the wrap
    // marks the last pixel of each word
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            word_cnt_r <= WORD_CNT_ZERO;
        end else if (pix_rise) begin
            word_cnt_r <= word_wrap ? WORD_CNT_ZERO
                                    : 5'(word_cnt_r + WORD_STEP_ONE); // see (RULE_02)
        end
    end

    // load and gated clocks update together, so all edges share one clock
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            load_r  <= 1'b0;
            gate_r  <= 1'b0;
            gated_r <= 1'b0;
        end else begin
            load_r  <= load_nxt;                                    // see (RULE_08)
            gate_r  <= gate_nxt;
            gated_r <= gated_nxt;
        end
    end

    // one-cycle feedback pulse at each load rise drives the comparator
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fb_pulse_r <= 1'b0;
        end else begin
            fb_pulse_r <= load_rise;                                // see (RULE_13)
        end
    end

    // phase-frequency comparator: the longer one input leads, the further
    // the tuning word moves, so the correction tracks the size of the error
    always_comb begin
        pfd_nxt = pfd_r;
        if (both_pulse) begin
            pfd_nxt = pfd_idle;
        end else if (ref_only) begin
            pfd_nxt = (pfd_r == pfd_down) ? pfd_idle : pfd_up;
        end else if (fb_only) begin
            pfd_nxt = (pfd_r == pfd_up) ? pfd_idle : pfd_down;
        end
    end

    always_comb begin
        case (pfd_r)
            pfd_up: begin
                freq_word_nxt = freq_up_sat;                        // see (RULE_04)
            end
            pfd_down: begin
                freq_word_nxt = freq_down_sat;                      // see (RULE_04)
            end
            default: begin
                freq_word_nxt = freq_word_r;                        // see (RULE_03)
            end
        endcase
    end

    // comparator state; a pulse on the other input while one leads
    // returns it to idle, so it never steers both ways at once
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pfd_r <= pfd_idle;
        end else begin
            pfd_r <= pfd_nxt;
        end
    end

    // tuning word holds its last value once the loop is locked;
    // a reset restarts it from the nominal rate
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            freq_word_r <= FREQ_INIT;
        end else begin
            freq_word_r <= freq_word_nxt;
        end
    end

    // differential pairs come from the same flops, so edges stay aligned
    assign pixel_clock_diff_p      = pix_r;                         // see (RULE_07)
    assign pixel_clock_diff_n      = !pix_r;

    // load clocks: free-running, then gated single and gated pair
    assign free_load_clock         = load_r;
    assign gated_load_clock_single = gated_r;
    assign gated_load_clock_diff_p = gated_r;                       // see (RULE_07)
    assign gated_load_clock_diff_n = !gated_r;

    // system side and tuning word
    assign system_clock_out        = sys_clk_r;
    assign oscillator_tune         = freq_word_r;
endmodule : video_clock_divider_pll_logic
`default_nettype wire

// ===== verif/vclk_asserts.sv
// port assertions for the video clock divider logic
`timescale 1ns/10ps
`default_nettype none
module vclk_checker
    import vclk_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        crystal_tick,
    input wire logic        video_gate_in,
    input wire logic        pixel_clock_diff_p,
    input wire logic        pixel_clock_diff_n,
    input wire logic        free_load_clock,
    input wire logic        gated_load_clock_single,
    input wire logic        gated_load_clock_diff_p,
    input wire logic        gated_load_clock_diff_n,
    input wire logic        system_clock_out,
    input wire logic [15:0] oscillator_tune
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence load_rise; $rose(free_load_clock); endsequence
    sequence pix_rise; $rose(pixel_clock_diff_p); endsequence
    pix_pair_a: assert property (pixel_clock_diff_n == !pixel_clock_diff_p)
        else $error("pixel pair not complementary");
    load_pair_a: assert property (gated_load_clock_diff_n != gated_load_clock_diff_p)
        else $error("load pair not complementary");
    gated_copy_a: assert property (gated_load_clock_single == gated_load_clock_diff_p)
        else $error("gated loads differ");
    gate_start_a: assert property (load_rise |-> gated_load_clock_single == $past(video_gate_in))
        else $error("gated load ignored gate");
    gate_hold_a: assert property ($stable(free_load_clock) |-> $stable(gated_load_clock_single))
        else $error("gated load truncated");
    load_sync_a: assert property (load_rise |-> pix_rise)
        else $error("load not on pixel edge");
    load_width_a: assert property ($fell(free_load_clock) |-> pix_rise)
        else $error("load not one pixel wide");
    sys_toggle_a: assert property (crystal_tick |=> $changed(system_clock_out))
        else $error("system clock missed tick");
    tune_range_a: assert property (oscillator_tune inside {[FREQ_MIN:FREQ_MAX]})
        else $error("tuning word out of range");
endmodule : vclk_checker
bind video_clock_divider_pll_logic vclk_checker chk (.clock, .reset_n,
    .crystal_tick, .video_gate_in, .pixel_clock_diff_p, .pixel_clock_diff_n,
    .free_load_clock, .gated_load_clock_single, .gated_load_clock_diff_p,
    .gated_load_clock_diff_n, .system_clock_out, .oscillator_tune);
`default_nettype wire

// ===== verif/shift_reg_model.sv
// video shift register: counts shifts between parallel loads
`timescale 1ns/10ps
`default_nettype none
module shift_reg_model (
    input  wire logic clock,
    input  wire logic shift_clock,
    input  wire logic load_strobe,
    output var int    shifts_seen
);
    int   count = 0;
    logic shift_d = 1'h0;
    logic load_d = 1'h0;
    // sampled mid-cycle so the pins have settled after their launch edge
    always @(negedge clock) begin
        shift_d <= shift_clock;
        load_d  <= load_strobe;
        if (load_strobe && !load_d) begin
            shifts_seen <= count;
            count       <= int'(shift_clock && !shift_d);
        end else if (shift_clock && !shift_d) begin
            count <= count + 1;
        end
    end
endmodule : shift_reg_model
`default_nettype wire

// ===== verif/tb_video_clock_divider_pll_logic.sv
// self-checking bench for the video clock divider logic
`timescale 1ns/10ps
`default_nettype none
module tb_video_clock_divider_pll_logic;
    logic clock = 1'h0, reset_n = 1'h0, crystal_tick = 1'h0;
    logic video_gate_in = 1'h0, free_d = 1'h0, gate_d = 1'h0, sys_d = 1'h0;
    logic [2:0] width_select = 3'h0;
    logic [1:0] ref_select = 2'h0;
    logic pixel_clock_diff_p, pixel_clock_diff_n, free_load_clock;
    logic gated_load_clock_single, system_clock_out;
    int failures = 0, check_count = 0, cycles = 0, tick_gap = 16, tick_cnt = 0;
    int n_free = 0, n_gate = 0, n_sys = 0, n_tick = 0, shifts;
    video_clock_divider_pll_logic dut (.clock, .reset_n, .crystal_tick,
        .width_select, .ref_select, .video_gate_in, .pixel_clock_diff_p,
        .pixel_clock_diff_n, .free_load_clock, .gated_load_clock_single,
        .gated_load_clock_diff_p(), .gated_load_clock_diff_n(),
        .system_clock_out, .oscillator_tune());
    shift_reg_model video_sr (.clock, .shift_clock(pixel_clock_diff_p),
        .load_strobe(gated_load_clock_single), .shifts_seen(shifts));
    initial forever #5 clock = ~clock;
    // the reference tick period is picked so the starting tune is on lock
    always @(posedge clock) begin
        tick_cnt = (tick_cnt + 1) % tick_gap;
        crystal_tick <= (tick_cnt == 0);
        if (++cycles == 70000) begin
            failures++;
            print_verdict();
        end
    end
    // outputs are counted mid-cycle, once they have settled
    always @(negedge clock) begin
        n_free += free_load_clock & !free_d;
        n_gate += gated_load_clock_single & !gate_d;
        n_sys += system_clock_out ^ sys_d;
        n_tick += crystal_tick;
        free_d = free_load_clock;
        gate_d = gated_load_clock_single;
        sys_d = system_clock_out;
    end
    task automatic check(string what, int exp, int got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic restart(logic [2:0] w, logic [1:0] r);
        reset_n <= 1'h0;
        width_select <= w;
        ref_select <= r;
        tick_gap = 64 * (w + 1) / (r + 1);
        repeat (6) @(posedge clock);
        reset_n <= 1'h1;
    endtask : restart
    task automatic div_ratio(logic [2:0] w, logic [1:0] r);
        int f0, t0, y0, d;
        restart(w, r);
        video_gate_in <= 1'h1;
        repeat (3000) @(posedge clock);
        f0 = n_free;
        t0 = n_tick;
        y0 = n_sys;
        repeat (20 * tick_gap * (r + 1)) @(posedge clock);
        check("pixels per load", 4 * (w + 1), shifts);
        d = (n_free - f0) - (n_tick - t0) / (r + 1);
        check("load rate", 1, int'(d inside {[-2:2]}));
        d = (n_sys - y0) - (n_tick - t0);
        check("system clock", 1, int'(d inside {[-1:1]}));
    endtask : div_ratio
    task automatic gate_control();
        int f0, g0;
        restart(3'h1, 2'h0);
        video_gate_in <= 1'h0;
        repeat (1000) @(posedge clock);
        g0 = n_gate;
        repeat (1280) @(posedge clock);
        check("gated while off", 0, n_gate - g0);
        video_gate_in <= 1'h1;
        repeat (300) @(posedge clock);
        f0 = n_free;
        g0 = n_gate;
        repeat (1280) @(posedge clock);
        check("gated while on", n_free - f0, n_gate - g0);
    endtask : gate_control
    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        div_ratio(3'h0, 2'h3);
        div_ratio(3'h3, 2'h1);
        div_ratio(3'h5, 2'h2);
        div_ratio(3'h7, 2'h3);
        div_ratio(3'h1, 2'h0);
        gate_control();
        print_verdict();
    end
endmodule : tb_video_clock_divider_pll_logic
`default_nettype wire
